// File: rtl/cobid_consts.svh
`ifndef COBID_CONSTS_SVH
`define COBID_CONSTS_SVH

`define COBID_NODE_W        6
`define COBID_ID_W          11
`define COBID_NODE_LIMIT    7'h40
`define COBID_CFG_OBJ       16'h5500
`define COBID_BASE_EMCY     11'h081
`define COBID_BASE_TXPDO1   11'h181
`define COBID_BASE_RXPDO1   11'h201
`define COBID_BASE_TXPDO2   11'h281
`define COBID_BASE_RXPDO2   11'h301
`define COBID_BASE_TXPDO3   11'h381
`define COBID_BASE_RXPDO3   11'h401
`define COBID_BASE_TXPDO4   11'h481
`define COBID_BASE_RXPDO4   11'h501
`define COBID_BASE_TXPDO5   11'h681
`define COBID_BASE_RXPDO5   11'h781
`define COBID_BASE_TXPDO6   11'h1c1
`define COBID_BASE_RXPDO6   11'h241
`define COBID_BASE_TXPDO7   11'h2c1
`define COBID_BASE_RXPDO7   11'h341
`define COBID_BASE_TXPDO8   11'h3c1
`define COBID_BASE_RXPDO8   11'h441
`define COBID_BASE_TXPDO9   11'h4c1
`define COBID_BASE_RXPDO9   11'h541
`define COBID_BASE_TXPDO10  11'h5c1
`define COBID_BASE_RXPDO10  11'h641
`define COBID_BASE_TXPDO11  11'h6c1
`define COBID_BASE_RXPDO11  11'h741
`define COBID_BASE_SDO_TX   11'h581
`define COBID_BASE_SDO_RX   11'h601
`define COBID_BASE_NMT_ERR  11'h701

`endif

// File: rtl/cobid_pkg.sv
package cobid_pkg;
   typedef enum logic [4:0] {
      COBID_OBJ_EMCY     = 5'h00,
      COBID_OBJ_TXPDO1   = 5'h01,
      COBID_OBJ_RXPDO1   = 5'h02,
      COBID_OBJ_TXPDO2   = 5'h03,
      COBID_OBJ_RXPDO2   = 5'h04,
      COBID_OBJ_TXPDO3   = 5'h05,
      COBID_OBJ_RXPDO3   = 5'h06,
      COBID_OBJ_TXPDO4   = 5'h07,
      COBID_OBJ_RXPDO4   = 5'h08,
      COBID_OBJ_TXPDO5   = 5'h09,
      COBID_OBJ_RXPDO5   = 5'h0a,
      COBID_OBJ_TXPDO6   = 5'h0b,
      COBID_OBJ_RXPDO6   = 5'h0c,
      COBID_OBJ_TXPDO7   = 5'h0d,
      COBID_OBJ_RXPDO7   = 5'h0e,
      COBID_OBJ_TXPDO8   = 5'h0f,
      COBID_OBJ_RXPDO8   = 5'h10,
      COBID_OBJ_TXPDO9   = 5'h11,
      COBID_OBJ_RXPDO9   = 5'h12,
      COBID_OBJ_TXPDO10  = 5'h13,
      COBID_OBJ_RXPDO10  = 5'h14,
      COBID_OBJ_TXPDO11  = 5'h15,
      COBID_OBJ_RXPDO11  = 5'h16,
      COBID_OBJ_SDO_TX   = 5'h17,
      COBID_OBJ_SDO_RX   = 5'h18,
      COBID_OBJ_NMT_ERR  = 5'h19
   } cobid_obj_t;

   typedef enum logic [1:0] {
      COBID_ST_IDLE = 2'b01,
      COBID_ST_DONE = 2'b10
   } cobid_state_t;
endpackage

// File: rtl/cobid_allocator.sv
// Contract
// - scheme applies only to node addresses below 64
// - scheme active once configuration object written with enable set, a write with enable clear turns it off
// - emergency ids 0x81 to 0xBF
// - first transmit pdo 0x181 to 0x1BF
// - first receive pdo 0x201 to 0x23F
// - second transmit pdo 0x281 to 0x2BF
// - second receive pdo 0x301 to 0x33F
// - third transmit pdo 0x381 to 0x3BF
// - third receive pdo 0x401 to 0x43F
// - fourth transmit pdo 0x481 to 0x4BF
// - fourth receive pdo 0x501 to 0x53F
// - service data responses 0x581 to 0x5BF
// - service data requests 0x601 to 0x63F
// - guarding, heartbeat, boot-up 0x701 to 0x73F
// - pdos five to eleven use own blocks
`timescale 1ns/1ps
`include "cobid_consts.svh"

module cobid_allocator (
   // clock and reset
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_rst,
   // configuration object write
   input  wire logic                     i_cfg_wr,
   input  wire logic [15:0]              i_cfg_index,
   input  wire logic                     i_cfg_enable,
   // lookup request
   input  wire logic                     i_req_valid,
   input  wire logic [6:0]               i_node_addr,
   input  wire cobid_pkg::cobid_obj_t    i_obj,
   // lookup answer
   output logic                          o_rsp_valid,
   output logic [`COBID_ID_W-1:0]        o_cob_id,
   output logic                          o_node_invalid,
   output logic                          o_scheme_off,
   // status
   output logic                          o_scheme_active
);

   // predefined connection set blocks, zero for any other object
   function automatic logic [`COBID_ID_W-1:0] std_base(input cobid_pkg::cobid_obj_t obj);
      logic [`COBID_ID_W-1:0] b;
      b = 11'h000;
      case (obj)
         cobid_pkg::COBID_OBJ_EMCY: begin
            b = `COBID_BASE_EMCY;
         end
         cobid_pkg::COBID_OBJ_TXPDO1: begin
            b = `COBID_BASE_TXPDO1;
         end
         cobid_pkg::COBID_OBJ_RXPDO1: begin
            b = `COBID_BASE_RXPDO1;
         end
         cobid_pkg::COBID_OBJ_TXPDO2: begin
            b = `COBID_BASE_TXPDO2;
         end
         cobid_pkg::COBID_OBJ_RXPDO2: begin
            b = `COBID_BASE_RXPDO2;
         end
         cobid_pkg::COBID_OBJ_TXPDO3: begin
            b = `COBID_BASE_TXPDO3;
         end
         cobid_pkg::COBID_OBJ_RXPDO3: begin
            b = `COBID_BASE_RXPDO3;
         end
         cobid_pkg::COBID_OBJ_TXPDO4: begin
            b = `COBID_BASE_TXPDO4;
         end
         cobid_pkg::COBID_OBJ_RXPDO4: begin
            b = `COBID_BASE_RXPDO4;
         end
         cobid_pkg::COBID_OBJ_SDO_TX: begin
            b = `COBID_BASE_SDO_TX;
         end
         cobid_pkg::COBID_OBJ_SDO_RX: begin
            b = `COBID_BASE_SDO_RX;
         end
         cobid_pkg::COBID_OBJ_NMT_ERR: begin
            b = `COBID_BASE_NMT_ERR;
         end
         default: begin
            b = 11'h000;
         end
      endcase
      return b;
   endfunction

   // extra transmit pdo blocks, zero for any other object
   function automatic logic [`COBID_ID_W-1:0] tx_extra_base(input cobid_pkg::cobid_obj_t obj);
      logic [`COBID_ID_W-1:0] b;
      b = 11'h000;
      case (obj)
         cobid_pkg::COBID_OBJ_TXPDO5: begin
            b = `COBID_BASE_TXPDO5;
         end
         cobid_pkg::COBID_OBJ_TXPDO6: begin
            b = `COBID_BASE_TXPDO6;
         end
         cobid_pkg::COBID_OBJ_TXPDO7: begin
            b = `COBID_BASE_TXPDO7;
         end
         cobid_pkg::COBID_OBJ_TXPDO8: begin
            b = `COBID_BASE_TXPDO8;
         end
         cobid_pkg::COBID_OBJ_TXPDO9: begin
            b = `COBID_BASE_TXPDO9;
         end
         cobid_pkg::COBID_OBJ_TXPDO10: begin
            b = `COBID_BASE_TXPDO10;
         end
         cobid_pkg::COBID_OBJ_TXPDO11: begin
            b = `COBID_BASE_TXPDO11;
         end
         default: begin
            b = 11'h000;
         end
      endcase
      return b;
   endfunction

   // extra receive pdo blocks, zero for any other object
   function automatic logic [`COBID_ID_W-1:0] rx_extra_base(input cobid_pkg::cobid_obj_t obj);
      logic [`COBID_ID_W-1:0] b;
      b = 11'h000;
      case (obj)
         cobid_pkg::COBID_OBJ_RXPDO5: begin
            b = `COBID_BASE_RXPDO5;
         end
         cobid_pkg::COBID_OBJ_RXPDO6: begin
            b = `COBID_BASE_RXPDO6;
         end
         cobid_pkg::COBID_OBJ_RXPDO7: begin
            b = `COBID_BASE_RXPDO7;
         end
         cobid_pkg::COBID_OBJ_RXPDO8: begin
            b = `COBID_BASE_RXPDO8;
         end
         cobid_pkg::COBID_OBJ_RXPDO9: begin
            b = `COBID_BASE_RXPDO9;
         end
         cobid_pkg::COBID_OBJ_RXPDO10: begin
            b = `COBID_BASE_RXPDO10;
         end
         cobid_pkg::COBID_OBJ_RXPDO11: begin
            b = `COBID_BASE_RXPDO11;
         end
         default: begin
            b = 11'h000;
         end
      endcase
      return b;
   endfunction

   // unused object codes fall back to the emergency block
   function automatic logic [`COBID_ID_W-1:0] base_of(input cobid_pkg::cobid_obj_t obj);
      logic [`COBID_ID_W-1:0] b;
      b = std_base(obj) | tx_extra_base(obj) | rx_extra_base(obj);
      if (b == 11'h000) begin
         b = `COBID_BASE_EMCY;
      end
      return b;
   endfunction

   // only nodes 1..63 fit the 6-bit offset of a block
   function automatic logic node_in_scheme(input logic [6:0] addr);
      logic ok;
      ok = (addr != 7'h00) && (addr < `COBID_NODE_LIMIT);
      return ok;
   endfunction

   // node 1 lands on the block base
   function automatic logic [`COBID_ID_W-1:0] id_of(input cobid_pkg::cobid_obj_t obj,
                                                     input logic [6:0]           addr);
      logic [`COBID_ID_W-1:0] offs;
      offs = {5'h00, addr[5:0]};
      return base_of(obj) + offs - 11'h001;
   endfunction

   // only the scheme object acts, other indices are ignored
   function automatic logic scheme_write(input logic wr, input logic [15:0] index);
      logic hit;
      hit = wr && (index == `COBID_CFG_OBJ);
      return hit;
   endfunction

   // scheme enable state
   logic scheme_active;
   logic next_scheme_active;

   always_comb begin
      next_scheme_active = scheme_active;
      if (scheme_write(i_cfg_wr, i_cfg_index)) begin
         next_scheme_active = i_cfg_enable;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         scheme_active <= 1'b0;
      end else begin
         scheme_active <= next_scheme_active;
      end
   end

   // address check shared by the identifier and invalid node flag groups
   logic addr_ok;

   assign addr_ok = node_in_scheme(i_node_addr);

   // answer strobe state
   cobid_pkg::cobid_state_t state;
   cobid_pkg::cobid_state_t next_state;

   always_comb begin
      next_state = cobid_pkg::COBID_ST_IDLE;
      unique case (state)
         cobid_pkg::COBID_ST_IDLE: begin
            if (i_req_valid) begin
               next_state = cobid_pkg::COBID_ST_DONE;
            end
         end
         cobid_pkg::COBID_ST_DONE: begin
            // back-to-back requests keep the strobe up
            if (i_req_valid) begin
               next_state = cobid_pkg::COBID_ST_DONE;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= cobid_pkg::COBID_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // answer identifier state
   logic [`COBID_ID_W-1:0] cob_id;
   logic [`COBID_ID_W-1:0] next_cob_id;

   always_comb begin
      next_cob_id = cob_id;
      if (i_req_valid) begin
         if (addr_ok && scheme_active) begin
            next_cob_id = id_of(i_obj, i_node_addr);
         end else begin
            // refused lookups read as zero
            next_cob_id = 11'h000;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cob_id <= 11'h000;
      end else begin
         cob_id <= next_cob_id;
      end
   end

   // invalid node flag state
   logic node_invalid;
   logic next_node_invalid;

   always_comb begin
      next_node_invalid = node_invalid;
      if (i_req_valid) begin
         next_node_invalid = !addr_ok;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         node_invalid <= 1'b0;
      end else begin
         node_invalid <= next_node_invalid;
      end
   end

   // scheme off flag, a write in the same cycle is not yet seen
   logic scheme_off;
   logic next_scheme_off;

   always_comb begin
      next_scheme_off = scheme_off;
      if (i_req_valid) begin
         next_scheme_off = !scheme_active;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         scheme_off <= 1'b0;
      end else begin
         scheme_off <= next_scheme_off;
      end
   end

   assign o_rsp_valid     = (state == cobid_pkg::COBID_ST_DONE);
   assign o_cob_id        = cob_id;
   assign o_node_invalid  = node_invalid;
   assign o_scheme_off    = scheme_off;
   assign o_scheme_active = scheme_active;

endmodule

// File: verif/cobid_allocator_asserts.sv
`timescale 1ns/1ps
module cobid_allocator_chk (
   input wire logic                  i_sys_clk,
   input wire logic                  i_rst,
   input wire logic                  i_cfg_wr,
   input wire logic [15:0]           i_cfg_index,
   input wire logic                  i_cfg_enable,
   input wire logic                  i_req_valid,
   input wire logic [6:0]            i_node_addr,
   input wire cobid_pkg::cobid_obj_t i_obj,
   input wire logic                  o_rsp_valid,
   input wire logic [10:0]           o_cob_id,
   input wire logic                  o_node_invalid,
   input wire logic                  o_scheme_off,
   input wire logic                  o_scheme_active
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire logic cfg_hit = i_cfg_wr && i_cfg_index == 16'h5500;
   wire logic node_ok = i_node_addr != 7'h00 && i_node_addr < 7'h40;
   wire logic hit     = i_req_valid && node_ok && o_scheme_active;
   property p_rsp; o_rsp_valid == $past(i_req_valid); endproperty
   a_rsp: assert property (p_rsp) else $error("answer strobe wrong");
   property p_act; cfg_hit |=> o_scheme_active == $past(i_cfg_enable); endproperty
   a_act: assert property (p_act) else $error("scheme enable not taken");
   property p_keep; !cfg_hit |=> $stable(o_scheme_active); endproperty
   a_keep: assert property (p_keep) else $error("scheme state moved");
   property p_off; i_req_valid && !o_scheme_active |=> o_scheme_off && o_cob_id == 11'h000; endproperty
   a_off: assert property (p_off) else $error("scheme off not flagged");
   property p_inv; i_req_valid && !node_ok |=> o_node_invalid && o_cob_id == 11'h000; endproperty
   a_inv: assert property (p_inv) else $error("bad node not flagged");
   property p_low; hit |=> !o_node_invalid && !o_scheme_off && {1'b0, o_cob_id[5:0]} == $past(i_node_addr); endproperty
   a_low: assert property (p_low) else $error("id low bits wrong");
   property p_emcy; hit && i_obj == cobid_pkg::COBID_OBJ_EMCY |=> o_cob_id == 11'h080 + $past(i_node_addr); endproperty
   a_emcy: assert property (p_emcy) else $error("emergency id wrong");
   property p_sdo; hit && i_obj == cobid_pkg::COBID_OBJ_SDO_RX |=> o_cob_id == 11'h600 + $past(i_node_addr); endproperty
   a_sdo: assert property (p_sdo) else $error("sdo request id wrong");
   c_on: cover property (cfg_hit && i_cfg_enable);
   c_inv: cover property (i_req_valid && !node_ok);
   c_hit: cover property (hit);
   c_race: cover property (cfg_hit && i_req_valid);
endmodule

bind cobid_allocator cobid_allocator_chk u_chk (.*);

// File: verif/cobid_net_node.sv
`timescale 1ns/1ps
module cobid_net_node (
   input  wire logic   i_sys_clk,
   output logic        o_cfg_wr,
   output logic [15:0] o_cfg_index,
   output logic        o_cfg_enable
);
   initial begin
      o_cfg_wr = 1'b0;
      o_cfg_index = 16'h0000;
      o_cfg_enable = 1'b0;
   end
   // one-cycle object write, index scrambled once released
   task automatic cfg(input logic [15:0] idx, input logic en);
      @(negedge i_sys_clk);
      o_cfg_wr = 1'b1;
      o_cfg_index = idx;
      o_cfg_enable = en;
      @(negedge i_sys_clk);
      o_cfg_wr = 1'b0;
      o_cfg_index = ~idx;
      o_cfg_enable = ~en;
   endtask
endmodule

// File: verif/test_cobid_allocator.sv
`timescale 1ns/1ps
module test_cobid_allocator;
   logic                  i_sys_clk   = 1'b0;
   logic                  i_rst       = 1'b1;
   logic                  i_req_valid = 1'b0;
   logic [6:0]            i_node_addr = 7'h00;
   cobid_pkg::cobid_obj_t i_obj       = cobid_pkg::COBID_OBJ_EMCY;
   logic                  cfg_wr, cfg_en, o_rsp_valid, o_node_invalid, o_scheme_off, o_scheme_active;
   logic [15:0]           cfg_index;
   logic [10:0]           o_cob_id;
   logic [6:0]            nd;
   int                    n_mismatch = 0, n_checks = 0, cyc = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   cobid_net_node net (.i_sys_clk(i_sys_clk), .o_cfg_wr(cfg_wr), .o_cfg_index(cfg_index), .o_cfg_enable(cfg_en));
   cobid_allocator DUT (.i_sys_clk, .i_rst, .i_cfg_wr(cfg_wr), .i_cfg_index(cfg_index), .i_cfg_enable(cfg_en),
      .i_req_valid, .i_node_addr, .i_obj, .o_rsp_valid, .o_cob_id, .o_node_invalid, .o_scheme_off, .o_scheme_active);
   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [10:0] base_of(input int c);
      int k;
      k = (c + 1) / 2;
      if (c == 0) return 11'h081;
      if (c == 23) return 11'h581;
      if (c == 24) return 11'h601;
      if (c == 25) return 11'h701;
      if (k == 5) return c[0] ? 11'h681 : 11'h781;
      return 11'((k < 5 ? (c[0] ? 'h181 : 'h201) : (c[0] ? 'h1c1 : 'h241)) + 'h100 * (k < 5 ? k - 1 : k - 6));
   endfunction
   // entered at a falling edge; requests stay up so calls run back to back
   task automatic look(input logic [6:0] a, input int c, input logic [10:0] id, input logic [1:0] fl);
      i_req_valid = 1'b1;
      i_node_addr = a;
      i_obj = cobid_pkg::cobid_obj_t'(c);
      @(negedge i_sys_clk);
      chk("rsp_valid", {10'h000, o_rsp_valid}, 11'h001);
      chk("cob_id", o_cob_id, id);
      chk("flags", {9'h000, o_node_invalid, o_scheme_off}, {9'h000, fl});
   endtask
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      void'($urandom(1117));
      repeat (6) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_rst = 1'b0;
      chk("active", {10'h000, o_scheme_active}, 11'h000);
      look(7'h05, 1, 11'h000, 2'b01);
      i_req_valid = 1'b0;
      net.cfg(16'h5501, 1'b1);
      chk("active", {10'h000, o_scheme_active}, 11'h000);
      look(7'h05, 1, 11'h000, 2'b01);
      i_req_valid = 1'b0;
      net.cfg(16'h5500, 1'b1);
      chk("active", {10'h000, o_scheme_active}, 11'h001);
      for (int c = 0; c < 26; c++) begin
         nd = 7'($urandom_range(1, 63));
         look(7'h01, c, base_of(c), 2'b00);
         look(7'h3f, c, base_of(c) + 11'h03e, 2'b00);
         look(nd, c, base_of(c) + 11'(nd) - 11'h001, 2'b00);
      end
      // strobe drops after one cycle, the identifier holds
      i_req_valid = 1'b0;
      @(negedge i_sys_clk);
      chk("rsp_valid", {10'h000, o_rsp_valid}, 11'h000);
      chk("cob_id", o_cob_id, base_of(25) + 11'(nd) - 11'h001);
      look(7'h02, 26, 11'h082, 2'b00);
      look(7'h00, 0, 11'h000, 2'b10);
      look(7'h40, 24, 11'h000, 2'b10);
      look(7'h7f, 25, 11'h000, 2'b10);
      // a lookup in the cycle of the write still sees the old state
      i_req_valid = 1'b0;
      fork
         net.cfg(16'h5500, 1'b0);
         begin
            @(negedge i_sys_clk);
            look(7'h05, 1, 11'h185, 2'b00);
         end
      join
      chk("active", {10'h000, o_scheme_active}, 11'h000);
      look(7'h05, 1, 11'h000, 2'b01);
      i_req_valid = 1'b0;
      net.cfg(16'h5500, 1'b1);
      chk("active", {10'h000, o_scheme_active}, 11'h001);
      // reset in mid-run clears the answer and the scheme
      i_rst = 1'b1;
      @(negedge i_sys_clk);
      chk("active", {10'h000, o_scheme_active}, 11'h000);
      chk("rsp_valid", {10'h000, o_rsp_valid}, 11'h000);
      chk("cob_id", o_cob_id, 11'h000);
      chk("flags", {9'h000, o_node_invalid, o_scheme_off}, 11'h000);
      i_rst = 1'b0;
      look(7'h05, 1, 11'h000, 2'b01);
      i_req_valid = 1'b0;
      results();
   end
endmodule
